/* hw/acl_pkg.sv */
package acl_pkg;

  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int         SLOT_W     = 20;
  localparam logic [3:0] FIRST_DATA = 4'h3;
  localparam logic [3:0] LAST_SLOT  = 4'hc;
  localparam logic [4:0] TAG_LAST   = 5'h0f;
  localparam logic [4:0] SLOT_LAST  = 5'h13;
  localparam logic [8:0] FRAME_BITS = 9'h100;
  localparam logic [1:0] CODEC_ID   = 2'h0;

  // ****************************************
  // Buffer and interrupt sources
  // ****************************************
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam logic [3:0] RST_MASK  = 4'h0;

  // ****************************************
  // Sample width codes
  // ****************************************
  typedef enum logic [1:0] {
    ACL_SZ20 = 2'h0,
    ACL_SZ18 = 2'h1,
    ACL_SZ16 = 2'h2,
    ACL_SZ10 = 2'h3
  } acl_size_t;

endpackage

/* hw/acl_buf_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface acl_buf_if;
  logic                        in_valid;
  logic [acl_pkg::SLOT_W-1:0]  in_data;
  logic                        in_ready;
  logic                        out_valid;
  logic [acl_pkg::SLOT_W-1:0]  out_data;
  logic                        out_ready;
  logic [1:0]                  count;

  modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, count);
  modport user  (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, count);
endinterface
`default_nettype wire

/* hw/acl_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
module acl_buf2 (
  // System
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  // Store side
  acl_buf_if.store   b
);
  typedef struct packed {
    logic [acl_pkg::SLOT_W-1:0] head;
    logic [acl_pkg::SLOT_W-1:0] tail;
    logic [1:0]                 cnt;
    logic                       rdy;
    logic                       vld;
  } acl_buf_st_t;

  acl_buf_st_t st;
  acl_buf_st_t n;
  logic        push;
  logic        pop;

  assign push = b.in_valid & st.rdy;
  assign pop  = b.out_ready & st.vld;

  // Head is always the oldest word, so read data comes from a register
  always_comb begin
    n = st;
    case ({push, pop})
      2'b10: begin
        if (st.cnt == 2'h0) begin
          n.head = b.in_data;
        end else begin
          n.tail = b.in_data;
        end
        n.cnt = st.cnt + 2'h1;
      end
      2'b01: begin
        n.head = st.tail;
        n.cnt  = st.cnt - 2'h1;
      end
      2'b11: begin
        if (st.cnt == 2'h1) begin
          n.head = b.in_data;
        end else begin
          n.head = st.tail;
          n.tail = b.in_data;
        end
      end
      default: begin
      end
    endcase
    n.rdy = (n.cnt != acl_pkg::BUF_DEPTH);
    n.vld = (n.cnt != 2'h0);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st     <= '0;
      st.rdy <= 1'b1;
    end else begin
      st <= n;
    end
  end

  assign b.in_ready  = st.rdy;
  assign b.out_valid = st.vld;
  assign b.out_data  = st.head;
  assign b.count     = st.cnt;

endmodule
`default_nettype wire

/* hw/acl_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// RL1 - Sample widths 10, 16, 18, 20 bits fit slots; variable rate supported
// RL2 - Codec pair, buffered streaming pair A, plain pair B
// RL3 - Up to ten slots may map onto one data channel
// RL4 - Codec supplies the 12.288 MHz bit clock timing every link bit
// RL5 - Controller drives frame sync marking each 48 kHz frame start
// RL6 - Controller drives serial out and samples serial in
// RL7 - Two clock domains; everything crossing is resynchronised
// RL8 - System clock must run faster than the bit clock
// RL9 - Interrupt output high while any source pending and unmasked
// RL10 - Each source enabled or disabled by separate writes; mask readable
// RL11 - Software ANDs mask with global status, then reads channel status
// RL12 - Frame is a tag slot plus twelve 20-bit slots each way
// RL13 - Outgoing slots: command, data, PCM, modem, surround, LFE, GPIO
// RL14 - Incoming slots: status, PCM, modem, mic, reserved, handset, IO
// RL15 - Each frame starts with a 16-bit tag slot
// RL16 - Tag: frame valid, twelve slot valid bits, two-bit codec id
// RL17 - Outgoing tag built from pending requests and previous slot requests
// RL18 - Codec space is 64 16-bit registers, even indices defined
// RL19 - Slot 1: bit 19 read flag, 18..12 index, rest zero
// RL20 - Slot 2: write data in 19..4, zeros; all zero on read
// RL21 - Codec reset is not driven here; a general pin does it
// RL22 - Codec control uses slots 1 and 2 only, both ways
// RL23 - Only slots 3..12 assignable to data channels; may stay unassigned
// RL24 - Unread sample is overwritten and overrun flag raised; channel A keeps its buffered words and drops the new one
// RL25 - Every slot shifted most significant bit first
// RL26 - Frame sync high for the 16 tag bits, 256 bits a frame
module acl_ctrl (
  // System
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // Link pins
  input  wire logic                i_link_bit_clock_in,
  input  wire logic                i_link_serial_in,
  output logic                     o_link_frame_sync_out,
  output logic                     o_link_serial_out,
  // Mode and slot assignment, bit n is slot n+3
  input  wire logic                i_enable,
  input  wire logic                i_vra_enable,
  input  wire logic [9:0]          i_out_assign_a,
  input  wire logic [9:0]          i_out_assign_b,
  input  wire logic [9:0]          i_in_assign_a,
  input  wire logic [9:0]          i_in_assign_b,
  input  wire acl_pkg::acl_size_t  i_cha_size,
  input  wire acl_pkg::acl_size_t  i_chb_size,
  // Codec command and status
  input  wire logic                i_cmd_valid,
  input  wire logic                i_cmd_read,
  input  wire logic [6:0]          i_cmd_index,
  input  wire logic [15:0]         i_cmd_data,
  output logic                     o_cmd_ready,
  output logic                     o_sts_valid,
  output logic [6:0]               o_sts_index,
  output logic [15:0]              o_sts_data,
  input  wire logic                i_sts_ack,
  output logic [1:0]               o_codec_id,
  // Channel A, streaming
  input  wire logic                i_cha_tx_valid,
  input  wire logic [19:0]         i_cha_tx_data,
  output logic                     o_cha_tx_ready,
  output logic                     o_cha_rx_valid,
  output logic [19:0]              o_cha_rx_data,
  input  wire logic                i_cha_rx_ready,
  output logic                     o_cha_overrun,
  input  wire logic                i_cha_ovr_clear,
  // Channel B, holding registers
  input  wire logic                i_chb_tx_valid,
  input  wire logic [19:0]         i_chb_tx_data,
  output logic                     o_chb_tx_ready,
  output logic                     o_chb_rx_valid,
  output logic [19:0]              o_chb_rx_data,
  input  wire logic                i_chb_rx_read,
  output logic                     o_chb_overrun,
  // Interrupt
  input  wire logic [3:0]          i_irq_enable,
  input  wire logic [3:0]          i_irq_disable,
  output logic [3:0]               o_interrupt_mask_view,
  output logic [3:0]               o_global_status_view,
  output logic                     o_irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic        bc1, bc2, bc3, di1, di2;
    logic [3:0]  slot;
    logic [4:0]  bitc;
    logic [19:0] sh;
    logic [19:0] rsh;
    logic        fs, run, fv;
    logic [12:1] vout;
    logic [15:0] itag;
    logic        cmd_free, cmd_rd, cmd_go;
    logic [6:0]  cmd_idx;
    logic [15:0] cmd_dat;
    logic        sts_v;
    logic [6:0]  sts_idx;
    logic [15:0] sts_dat;
    logic [9:0]  sreq;
    logic        btx_rdy;
    logic [19:0] btx;
    logic        brx_v;
    logic [19:0] brx;
    logic        b_ovr, a_ovr, a_pop, a_push;
    logic [19:0] a_pdat;
    logic [3:0]  mask;
    logic        irq;
  } acl_st_t;

  acl_st_t     st;
  acl_st_t     n;
  logic        rise;
  logic        fall;
  logic [3:0]  src;
  acl_buf_if   a_tx ();
  acl_buf_if   a_rx ();

  // ****************************************
  // Width fitting
  // ****************************************
  function automatic logic [19:0] tx_fit(input acl_pkg::acl_size_t sz, input logic [19:0] d);
    unique case (sz)
      acl_pkg::ACL_SZ18: tx_fit = {d[17:0], 2'h0};
      acl_pkg::ACL_SZ16: tx_fit = {d[15:0], 4'h0};
      acl_pkg::ACL_SZ10: tx_fit = {d[9:0], 10'h000};
      default:           tx_fit = d;
    endcase
  endfunction

  function automatic logic [19:0] rx_fit(input acl_pkg::acl_size_t sz, input logic [19:0] w);
    unique case (sz)
      acl_pkg::ACL_SZ18: rx_fit = {2'h0, w[19:2]};
      acl_pkg::ACL_SZ16: rx_fit = {4'h0, w[19:4]};
      acl_pkg::ACL_SZ10: rx_fit = {10'h000, w[19:10]};
      default:           rx_fit = w;
    endcase
  endfunction

  // ****************************************
  // Channel A buffers
  // ****************************************
  acl_buf2 u_atx (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .b     (a_tx.store)
  );

  acl_buf2 u_arx (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .b     (a_rx.store)
  );

  assign a_tx.in_valid  = i_cha_tx_valid;
  assign a_tx.in_data   = tx_fit(i_cha_size, i_cha_tx_data); // [RL1]
  assign a_tx.out_ready = st.a_pop;
  assign a_rx.in_valid  = st.a_push;
  assign a_rx.in_data   = st.a_pdat;
  assign a_rx.out_ready = i_cha_rx_ready;

  // Edges seen two flops late; needs the faster system clock [RL7] [RL8]
  assign rise = st.bc2 & ~st.bc3;
  assign fall = ~st.bc2 & st.bc3;
  assign src  = {st.a_ovr, st.b_ovr, st.brx_v, st.sts_v};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [4:0]  lb;
    logic [19:0] w;
    logic [1:0]  na;
    logic        bused;
    logic        ok;
    logic [12:1] vo;
    logic [15:0] tg;
    logic [3:0]  di;
    lb    = (st.slot == 4'h0) ? acl_pkg::TAG_LAST : acl_pkg::SLOT_LAST;
    w     = {st.rsh[18:0], st.di2};
    na    = 2'h0;
    bused = 1'b0;
    ok    = 1'b0;
    vo    = '0;
    tg    = '0;
    di    = 4'h0;
    n     = st;
    n.bc1 = i_link_bit_clock_in; // [RL7]
    n.bc2 = st.bc1;
    n.bc3 = st.bc2;
    n.di1 = i_link_serial_in;
    n.di2 = st.di1;
    n.a_pop  = 1'b0;
    n.a_push = 1'b0;
    // Clears first so that a same-cycle hardware set wins
    if (i_sts_ack) begin
      n.sts_v = 1'b0;
    end
    if (i_chb_rx_read) begin
      n.brx_v = 1'b0;
      n.b_ovr = 1'b0;
    end
    if (i_cha_ovr_clear) begin
      n.a_ovr = 1'b0;
    end
    if (i_cmd_valid && st.cmd_free) begin
      n.cmd_free = 1'b0;
      n.cmd_rd   = i_cmd_read;
      n.cmd_idx  = i_cmd_index; // [RL18]
      n.cmd_dat  = i_cmd_data;
    end
    if (i_chb_tx_valid && st.btx_rdy) begin
      n.btx_rdy = 1'b0;
      n.btx     = tx_fit(i_chb_size, i_chb_tx_data); // [RL1] [RL2]
    end
    // Transmit side, on bit clock rising edges
    if (rise) begin
      if (!i_enable) begin
        n.run = 1'b0;
        n.fs  = 1'b0;
        n.sh  = '0;
      end else if (!st.run || st.bitc == lb) begin
        n.run  = 1'b1;
        n.bitc = 5'h00;
        n.slot = (!st.run || st.slot == acl_pkg::LAST_SLOT) ? 4'h0 : st.slot + 4'h1; // [RL12]
        n.fs   = (n.slot == 4'h0); // [RL5] [RL26]
        di     = n.slot - acl_pkg::FIRST_DATA;
        if (n.slot == 4'h0) begin
          vo[1] = ~st.cmd_free; // [RL22]
          vo[2] = ~st.cmd_free & ~st.cmd_rd;
          for (int s = 3; s <= 12; s++) begin
            ok = ~i_vra_enable | ~st.sreq[s-3]; // [RL17]
            if (ok && i_out_assign_a[s-3]) begin // [RL3] [RL23]
              if (na < a_tx.count) begin
                vo[s] = 1'b1;
                na    = na + 2'h1;
              end
            end else if (ok && i_out_assign_b[s-3] && !bused && !st.btx_rdy) begin
              vo[s] = 1'b1;
              bused = 1'b1;
            end
          end
          tg[15] = |vo; // [RL16]
          for (int s = 1; s <= 12; s++) begin
            tg[15-s] = vo[s];
          end
          tg[1:0]  = acl_pkg::CODEC_ID;
          n.vout   = vo;
          n.fv     = |vo;
          n.cmd_go = ~st.cmd_free;
          n.sh     = {tg, 4'h0}; // [RL15] [RL17]
        end else if (n.slot == 4'h1) begin
          n.sh = st.cmd_go ? {st.cmd_rd, st.cmd_idx, 12'h000} : '0; // [RL19] [RL13]
        end else if (n.slot == 4'h2) begin
          n.sh = (st.cmd_go && !st.cmd_rd) ? {st.cmd_dat, 4'h0} : '0; // [RL20]
          if (st.cmd_go) begin
            n.cmd_free = 1'b1;
          end
        end else if (st.vout[n.slot]) begin
          if (i_out_assign_a[di]) begin
            n.sh    = a_tx.out_data; // [RL2]
            n.a_pop = 1'b1;
          end else begin
            n.sh      = st.btx;
            n.btx_rdy = 1'b1;
          end
        end else begin
          n.sh = '0;
        end
      end else begin
        n.bitc = st.bitc + 5'h01;
        n.sh   = {st.sh[18:0], 1'b0}; // [RL25] [RL6]
      end
    end
    // Receive side, sampled on bit clock falling edges
    if (fall && st.run) begin
      n.rsh = w; // [RL6] [RL25]
      if (st.bitc == lb) begin
        di = st.slot - acl_pkg::FIRST_DATA;
        if (st.slot == 4'h0) begin
          n.itag = w[15:0];
        end else if (st.slot == 4'h1) begin
          if (st.itag[14]) begin // [RL22]
            n.sts_idx = w[18:12];
            for (int k = 0; k < 10; k++) begin
              n.sreq[k] = w[11-k]; // [RL17]
            end
          end
        end else if (st.slot == 4'h2) begin
          if (st.itag[13]) begin
            n.sts_dat = w[19:4];
            n.sts_v   = 1'b1;
          end
        end else if (st.itag[4'hf - st.slot]) begin
          if (i_in_assign_a[di]) begin // [RL23]
            if (a_rx.in_ready) begin
              n.a_push = 1'b1;
              n.a_pdat = rx_fit(i_cha_size, w); // [RL1]
            end else begin
              n.a_ovr = 1'b1; // [RL24]
            end
          end else if (i_in_assign_b[di]) begin
            if (st.brx_v && !i_chb_rx_read) begin
              n.b_ovr = 1'b1; // [RL24]
            end
            n.brx   = rx_fit(i_chb_size, w);
            n.brx_v = 1'b1;
          end
        end
      end
    end
    // Interrupt mask and line
    n.mask = (st.mask & ~i_irq_disable) | i_irq_enable; // [RL10]
    n.irq  = |(src & st.mask); // [RL9]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st          <= '0;
      st.cmd_free <= 1'b1;
      st.btx_rdy  <= 1'b1;
      st.mask     <= acl_pkg::RST_MASK;
    end else begin
      st <= n;
    end
  end

  // Codec reset is left to a general pin [RL21]
  assign o_link_frame_sync_out = st.fs;
  assign o_link_serial_out     = st.sh[19];
  assign o_cmd_ready           = st.cmd_free;
  assign o_sts_valid           = st.sts_v;
  assign o_sts_index           = st.sts_idx;
  assign o_sts_data            = st.sts_dat;
  assign o_codec_id            = st.itag[1:0];
  assign o_cha_tx_ready        = a_tx.in_ready;
  assign o_cha_rx_valid        = a_rx.out_valid;
  assign o_cha_rx_data         = a_rx.out_data;
  assign o_cha_overrun         = st.a_ovr;
  assign o_chb_tx_ready        = st.btx_rdy;
  assign o_chb_rx_valid        = st.brx_v;
  assign o_chb_rx_data         = st.brx;
  assign o_chb_overrun         = st.b_ovr;
  assign o_interrupt_mask_view = st.mask;
  assign o_global_status_view  = src;
  assign o_irq                 = st.irq;

  // ****************************************
  // Checks
  // ****************************************
  logic [8:0] rcnt;
  logic       seen;

  always_ff @(posedge i_clk) begin
    if (i_rst || !st.run) begin
      rcnt <= 9'h000;
      seen <= 1'b0;
    end else if (st.fs && !$past(st.fs)) begin
      rcnt <= 9'h000;
      seen <= 1'b1;
    end else if (rise) begin
      rcnt <= rcnt + 9'h001;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  frame_len_a: assert property ($rose(st.fs) && seen |-> rcnt == acl_pkg::FRAME_BITS) // [RL26]
    else $error("frame is not 256 bit clocks");
  sync_start_a: assert property ($rose(st.fs) |-> st.slot == 4'h0 && st.bitc == 5'h00) // [RL5]
    else $error("frame sync rose away from frame start");
  tag_bits_a: assert property ($rose(st.fs) |-> st.sh[19] == (|st.vout) && st.sh[18] == st.vout[1]) // [RL16]
    else $error("tag bits do not match slot validity");
  slot_wrap_a: assert property (rise && i_enable && st.run && st.slot == 4'hc
    && st.bitc == 5'h13 |=> st.slot == 4'h0 && st.fs) // [RL12]
    else $error("frame did not wrap after slot 12");
  msb_first_a: assert property (rise && i_enable && st.run
    && st.bitc < ((st.slot == 4'h0) ? 5'h0f : 5'h13) |=> st.sh[19] == $past(st.sh[18])) // [RL25]
    else $error("serial out is not shifting msb first");
  cmd_addr_a: assert property (rise && i_enable && st.run && st.slot == 4'h0 && st.bitc == 5'h0f
    && st.cmd_go |=> st.sh == {st.cmd_rd, st.cmd_idx, 12'h000}) // [RL19]
    else $error("slot 1 command word wrong");
  read_zero_a: assert property (rise && i_enable && st.run && st.slot == 4'h1 && st.bitc == 5'h13
    && st.cmd_go && st.cmd_rd |=> st.sh == 20'h00000 && st.cmd_free) // [RL20]
    else $error("slot 2 not zero on a read");
  b_overrun_a: assert property ($rose(st.b_ovr) |-> $past(st.brx_v) && st.brx_v) // [RL24]
    else $error("overrun raised without an unread word");
  irq_cause_a: assert property (st.irq |-> $past(|(src & st.mask))) // [RL9]
    else $error("interrupt without unmasked pending source");
  mask_set_a: assert property (i_irq_enable[2] && !i_irq_disable[2] // [RL10]
    |=> st.mask[2] ##1 (st.mask[2] || $past(i_irq_disable[2])))
    else $error("enable write did not set mask");

  frame_seen_c: cover property ($rose(st.fs) && seen);
  cmd_sent_c: cover property (st.cmd_go && st.slot == 4'h2);
  b_overrun_c: cover property ($rose(st.b_ovr));
  a_push_c: cover property (st.a_push);

endmodule
`default_nettype wire

/* verif/acl_codec_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acl_codec_model (
  // Link pins
  output logic      o_bit_clk,
  output logic      o_serial,
  input  wire logic i_frame_sync,
  input  wire logic i_serial
);
  logic [255:0] in_frame;
  logic [255:0] cur_frame;
  logic [255:0] cap_frame;
  logic [255:0] got_frame;
  logic [255:0] cap_sync;
  logic [255:0] got_sync;
  logic         sync_q;
  int           k;
  int           b;
  int           nframes;

  initial begin
    o_bit_clk = 1'b0;
    o_serial = 1'b0;
    in_frame = '0;
    cur_frame = '0;
    sync_q = 1'b0;
    k = -1;
    nframes = 0;
  end

  // ****************************************
  // Free-running bit clock, 400 ns
  // ****************************************
  always #200 o_bit_clk = ~o_bit_clk;

  // Sample one bit period late, so the controller's resync delay never races us
  always @(posedge o_bit_clk) begin
    if (i_frame_sync && !sync_q)
      k = 1;
    else if (k >= 0)
      k = (k + 1) % 256;
    sync_q = i_frame_sync;
    if (k >= 0) begin
      b = (k + 255) % 256;
      cap_frame[255 - b] = i_serial;
      cap_sync[255 - b] = i_frame_sync;
      if (k == 0) begin
        got_frame = cap_frame;
        got_sync = cap_sync;
        cur_frame = in_frame;
        nframes = nframes + 1;
      end
      o_serial <= cur_frame[255 - k];
    end
  end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // Hookup
  // ****************************************
  logic i_clk, i_rst, i_link_bit_clock_in, i_link_serial_in, o_link_frame_sync_out;
  logic o_link_serial_out, i_enable, i_vra_enable, i_cmd_valid, i_cmd_read, o_cmd_ready;
  logic o_sts_valid, i_sts_ack, i_cha_tx_valid, o_cha_tx_ready, o_cha_rx_valid;
  logic i_cha_rx_ready, o_cha_overrun, i_cha_ovr_clear, i_chb_tx_valid, o_chb_tx_ready;
  logic o_chb_rx_valid, i_chb_rx_read, o_chb_overrun, o_irq;
  logic [9:0]         i_out_assign_a, i_out_assign_b, i_in_assign_a, i_in_assign_b;
  acl_pkg::acl_size_t i_cha_size, i_chb_size;
  logic [6:0]         i_cmd_index, o_sts_index, idx, sidx;
  logic [15:0]        i_cmd_data, o_sts_data, sdat;
  logic [19:0]        i_cha_tx_data, o_cha_rx_data, i_chb_tx_data, o_chb_rx_data;
  logic [19:0]        cd, wa0, wa1, wb, t;
  logic [1:0]         o_codec_id, cid;
  logic [11:0]        rq;
  logic [3:0]         i_irq_enable, i_irq_disable, o_interrupt_mask_view, o_global_status_view;
  int                 failures = 0;
  int                 total_checks = 0;
  int                 sh;

  acl_ctrl acl_ctrl_i (.i_clk, .i_rst, .i_link_bit_clock_in, .i_link_serial_in,
    .o_link_frame_sync_out, .o_link_serial_out, .i_enable, .i_vra_enable, .i_out_assign_a,
    .i_out_assign_b, .i_in_assign_a, .i_in_assign_b, .i_cha_size, .i_chb_size, .i_cmd_valid,
    .i_cmd_read, .i_cmd_index, .i_cmd_data, .o_cmd_ready, .o_sts_valid, .o_sts_index,
    .o_sts_data, .i_sts_ack, .o_codec_id, .i_cha_tx_valid, .i_cha_tx_data, .o_cha_tx_ready,
    .o_cha_rx_valid, .o_cha_rx_data, .i_cha_rx_ready, .o_cha_overrun, .i_cha_ovr_clear,
    .i_chb_tx_valid, .i_chb_tx_data, .o_chb_tx_ready, .o_chb_rx_valid, .o_chb_rx_data,
    .i_chb_rx_read, .o_chb_overrun, .i_irq_enable, .i_irq_disable, .o_interrupt_mask_view,
    .o_global_status_view, .o_irq);

  acl_codec_model acl_codec_model_i (.o_bit_clk(i_link_bit_clock_in),
    .o_serial(i_link_serial_in), .i_frame_sync(o_link_frame_sync_out),
    .i_serial(o_link_serial_out));

  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic clks(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic frame;
    @(acl_codec_model_i.nframes);
  endtask

  function automatic logic [19:0] slot(input int s);
    logic [255:0] f;
    f = acl_codec_model_i.got_frame;
    if (s == 0)
      return {4'h0, f[255:240]};
    return f[255 - 16 - 20 * (s - 1) -: 20];
  endfunction

  function automatic logic [255:0] mk(input logic [1:0] id, input logic [19:0] s3, s4, s5);
    return {1'b1, 12'hf80, 1'b0, id, 1'b0, sidx, rq, sdat, 4'h0, s3, s4, s5, 140'h0};
  endfunction

  // Channel 0 command, 1 streaming A, 2 holding B
  task automatic put(input int ch, input logic rd, input logic [6:0] ix, input logic [19:0] d);
    int n;
    n = 0;
    i_cmd_read = rd;
    i_cmd_index = ix;
    i_cmd_data = d[15:0];
    i_cha_tx_data = d;
    i_chb_tx_data = d;
    i_cmd_valid = (ch == 0);
    i_cha_tx_valid = (ch == 1);
    i_chb_tx_valid = (ch == 2);
    do begin
      @(posedge i_clk);
      n++;
    end while ((ch == 0 ? o_cmd_ready : ch == 1 ? o_cha_tx_ready : o_chb_tx_ready) !== 1'b1
               && n < 6000);
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    i_cha_tx_valid = 1'b0;
    i_chb_tx_valid = 1'b0;
    chk("handshake", 1, n < 6000);
    clks(1);
  endtask

  task automatic pop_a(input logic [19:0] e);
    chk("cha_rx_valid", 1, o_cha_rx_valid);
    chk("cha_rx_data", e, o_cha_rx_data);
    i_cha_rx_ready = 1'b1;
    clks(1);
    i_cha_rx_ready = 1'b0;
    clks(1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    i_rst = 1'b1;
    i_enable = 1'b1;
    i_vra_enable = 1'b0;
    i_out_assign_a = 10'h003;
    i_out_assign_b = 10'h004;
    i_in_assign_a = 10'h003;
    i_in_assign_b = 10'h004;
    i_cha_size = acl_pkg::ACL_SZ20;
    i_chb_size = acl_pkg::ACL_SZ20;
    {i_cmd_valid, i_cmd_read, i_cmd_index, i_cmd_data, i_sts_ack, rq} = '0;
    {i_cha_tx_valid, i_cha_tx_data, i_cha_rx_ready, i_cha_ovr_clear} = '0;
    {i_chb_tx_valid, i_chb_tx_data, i_chb_rx_read, i_irq_enable, i_irq_disable} = '0;
    void'($urandom(32'haa2c6586));
    clks(10);
    i_rst = 1'b0;
    chk("ready_rst", 3'h7, {o_cmd_ready, o_cha_tx_ready, o_chb_tx_ready});
    chk("flags_rst", 0, {o_global_status_view, o_interrupt_mask_view, o_irq});
    frame();
    frame();
    // Write command with both data channels loaded
    frame();
    clks(40);
    idx = 7'($urandom) & 7'h7e;
    cd = 20'($urandom);
    wa0 = 20'($urandom);
    wa1 = 20'($urandom);
    wb = 20'($urandom);
    put(0, 1'b0, idx, cd);
    put(1, 1'b0, 7'h00, wa0);
    put(1, 1'b0, 7'h00, wa1);
    chk("cha_full", 0, o_cha_tx_ready);
    put(2, 1'b0, 7'h00, wb);
    frame();
    frame();
    chk("tag", 20'h0fc00, slot(0));
    chk("slot1", {1'b0, idx, 12'h000}, slot(1));
    chk("slot2", {cd[15:0], 4'h0}, slot(2));
    chk("slot3", wa0, slot(3));
    chk("slot4", wa1, slot(4));
    chk("slot5", wb, slot(5));
    chk("sync_hi", 16'hffff, acl_codec_model_i.got_sync[255:240]);
    chk("sync_lo", 0, acl_codec_model_i.got_sync[239:0] != '0);
    chk("ready_back", 3'h7, {o_cmd_ready, o_cha_tx_ready, o_chb_tx_ready});
    // Read command, taken after this frame's tag is built
    clks(40);
    idx = 7'($urandom) & 7'h7e;
    put(0, 1'b1, idx, 20'($urandom));
    frame();
    frame();
    t = slot(0);
    chk("tag_rd", 8'hc0, {t[15:14], t[12:10], t[2:0]});
    chk("slot1_rd", {1'b1, idx, 12'h000}, slot(1));
    chk("slot2_rd", 0, slot(2));
    // Receive at every sample width
    for (int i = 0; i < 4; i++) begin
      i_cha_size = acl_pkg::acl_size_t'(i);
      i_chb_size = acl_pkg::acl_size_t'(i);
      sh = (i == 0) ? 0 : (i == 1) ? 2 : (i == 2) ? 4 : 10;
      sidx = 7'($urandom) & 7'h7e;
      sdat = 16'($urandom);
      cid = 2'($urandom);
      wa0 = 20'($urandom);
      wa1 = 20'($urandom);
      wb = 20'($urandom);
      acl_codec_model_i.in_frame = mk(cid, wa0, wa1, wb);
      frame();
      acl_codec_model_i.in_frame = '0;
      frame();
      clks(30);
      chk("sts", {1'b1, sidx, sdat}, {o_sts_valid, o_sts_index, o_sts_data});
      chk("codec_id", cid, o_codec_id);
      pop_a(wa0 >> sh);
      pop_a(wa1 >> sh);
      chk("chb_rx", {2'h2, wb >> sh}, {o_chb_rx_valid, o_chb_overrun, o_chb_rx_data});
      i_sts_ack = 1'b1;
      i_chb_rx_read = 1'b1;
      clks(1);
      i_sts_ack = 1'b0;
      i_chb_rx_read = 1'b0;
      clks(2);
      chk("rx_clear", 0, {o_sts_valid, o_chb_rx_valid, o_cha_rx_valid});
    end
    // Two frames unread: overruns and interrupt masking
    i_cha_size = acl_pkg::ACL_SZ20;
    i_chb_size = acl_pkg::ACL_SZ20;
    i_irq_enable = 4'hc;
    clks(1);
    i_irq_enable = 4'h0;
    chk("mask_en", 4'hc, o_interrupt_mask_view);
    wa0 = 20'($urandom);
    wa1 = 20'($urandom);
    acl_codec_model_i.in_frame = mk(2'h0, wa0, wa1, 20'($urandom));
    frame();
    wb = 20'($urandom);
    acl_codec_model_i.in_frame = mk(2'h0, 20'($urandom), 20'($urandom), wb);
    frame();
    acl_codec_model_i.in_frame = '0;
    frame();
    clks(30);
    chk("gstat", 4'hf, o_global_status_view);
    chk("irq_on", 1, o_irq);
    chk("chb_over", wb, o_chb_rx_data);
    i_irq_disable = 4'h8;
    clks(1);
    i_irq_disable = 4'h0;
    clks(2);
    chk("irq_b", 5'h14, {o_irq, o_interrupt_mask_view});
    i_chb_rx_read = 1'b1;
    clks(1);
    i_chb_rx_read = 1'b0;
    clks(2);
    chk("irq_off", 0, {o_irq, o_chb_overrun});
    i_cha_ovr_clear = 1'b1;
    clks(1);
    i_cha_ovr_clear = 1'b0;
    clks(1);
    chk("a_over_clr", 0, o_cha_overrun);
    pop_a(wa0);
    pop_a(wa1);
    // Variable rate: codec declines slot 3, so the word moves to slot 4
    rq = 12'h800;
    acl_codec_model_i.in_frame = mk(2'h0, 20'h00000, 20'h00000, 20'h00000);
    frame();
    acl_codec_model_i.in_frame = '0;
    i_vra_enable = 1'b1;
    frame();
    clks(40);
    put(1, 1'b0, 7'h00, wa0);
    frame();
    frame();
    chk("tag_vra", 20'h08800, slot(0));
    chk("slot4_vra", wa0, slot(4));
    // Link goes quiet when disabled
    i_enable = 1'b0;
    clks(100);
    chk("link_idle", 0, {o_link_frame_sync_out, o_link_serial_out});
    report_and_stop();
  end

  initial begin
    repeat (80000) @(posedge i_clk);
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
